// ==== verilog/lamp_pkg.sv ====
/*
  Shared constants and types for the network indicator lamp driver.
  Assumes a 200 MHz system clock; all times are derived from it.
*/
package lamp_pkg;

  // System clock rate and the millisecond tick derived from it.
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;

  // Pattern phase times in milliseconds.
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_GAP_MS = 200;
  localparam int unsigned FLASH_DARK_MS = 1000;

  // Lengths of the repeating single and double flash frames.
  localparam int unsigned SINGLE_FRAME_MS = FLASH_ON_MS + FLASH_DARK_MS;
  localparam int unsigned DOUBLE_FRAME_MS = 2 * FLASH_ON_MS + FLASH_GAP_MS + FLASH_DARK_MS;

  // Reset values of the prescaler and the flash frame counters.
  localparam logic [17:0] PRESCALE_RST = 18'h00000;
  localparam logic [10:0] MS_RST = 11'h000;

  // Lamp display pattern codes, one-hot.
  typedef enum logic [5:0] {
    PAT_OFF     = 6'h01,
    PAT_ON      = 6'h02,
    PAT_FLICKER = 6'h04,
    PAT_BLINK   = 6'h08,
    PAT_SINGLE  = 6'h10,
    PAT_DOUBLE  = 6'h20
  } pattern_t;

  // Slave communication state, one-hot.
  typedef enum logic [4:0] {
    ESM_INIT   = 5'h01,
    ESM_PREOP  = 5'h02,
    ESM_BOOT   = 5'h04,
    ESM_SAFEOP = 5'h08,
    ESM_OP     = 5'h10
  } esm_state_t;

  // Error flags from the slave logic.
  typedef struct packed {
    logic critical;     // Critical fault such as watchdog timeout.
    logic sm_watchdog;  // Sync manager watchdog fault.
    logic autonomous;   // State changed by the slave on its own.
    logic refused;      // Requested state change refused.
  } comm_err_t;

  // Status of one communication port.
  typedef struct packed {
    logic link;     // Link established.
    logic traffic;  // Frames passing.
    logic rx_error; // Erroneous data received.
  } port_stat_t;

  // All generated pattern waveforms.
  typedef struct packed {
    logic flicker;
    logic blink;
    logic single;
    logic dbl;
  } wave_t;

endpackage

// ==== verilog/fieldbus_status_led_driver.sv ====
/*
  Network indicator lamp driver: pattern generator plus lamp mapping for the
  run, fault, per-port link/activity, per-port line fault and safety lamps.
  Assumes all inputs are synchronous to hclk and that the register bus is
  used only for pattern override and status readback.
*/
// Local design decisions: the address map and the AHB-Lite register port.
// Notes on behaviour
// - Flicker toggles every 50 ms, a 10 Hz cycle.
// - Blink toggles every 200 ms, a 2.5 Hz cycle.
// - Single flash: lit 200 ms, dark 1000 ms, repeating.
// - Double flash: lit 200, dark 200, lit 200, dark 1000 ms.
// - Steady on never toggles; off never lights.
// - Run lamp dark in Init or without power.
// - Run lamp blinks in Pre-Operational.
// - Run lamp single flashes in Safe-Operational.
// - Run lamp steady in Operational.
// - Fault lamp blinks on refused state change, dark with no fault.
// - Fault lamp single flashes after autonomous state change from internal fault.
// - Fault lamp double flashes on sync manager watchdog fault.
// - Fault lamp steady on critical fault.
// - Each port has its own link/activity lamp driven by its status.
// - Link lamp dark without link or power.
// - Link lamp steady with link and no traffic.
// - Link lamp flickers with link and traffic.
// - Line fault lamp lit while its port receives bad data.
// - Safety lamp lit when functional safety can be activated.
`timescale 1ns/1ps

module fieldbus_status_led_driver #(
  parameter int unsigned TICK_CYCLES = lamp_pkg::TICK_CYCLES  // Clock cycles per millisecond.
) (
  input wire logic hclk, // System clock, 200 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic power_good, // Power present for the network interface.
  input wire lamp_pkg::esm_state_t esm_state, // Slave communication state.
  input wire lamp_pkg::comm_err_t comm_err, // Communication fault flags.
  input wire lamp_pkg::port_stat_t in_port_connector, // In port status.
  input wire lamp_pkg::port_stat_t out_port_connector, // Out port status.
  input wire logic safety_ready, // Functional safety can be activated.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hsel, // AHB slave select.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  output logic run_state_lamp, // Green run lamp.
  output logic comm_fault_lamp, // Red fault lamp.
  output logic [1:0] link_act_lamp, // Link lamps, bit 0 in port, bit 1 out port.
  output logic [1:0] line_fault_lamp, // Line fault lamps, bit 0 in, bit 1 out.
  output logic safety_ready_lamp // Green safety lamp.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map of the override and status words.
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // Whole module state.
  typedef struct packed {
    logic [17:0] prescale;
    logic tick;
    logic [5:0] flick_ms;
    logic flicker;
    logic [7:0] blink_ms;
    logic blink;
    logic [10:0] single_ms;
    logic [10:0] double_ms;
    logic lamp_test;     // Software forces every lamp on.
    logic lamp_blank;    // Software forces every lamp off.
    logic wr_pend;
    logic [3:0] wr_addr;
    logic [31:0] rdata;
    logic run;
    logic fault;
    logic [1:0] link;
    logic [1:0] line;
    logic safety;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  lamp_pkg::wave_t wave;
  lamp_pkg::pattern_t run_pat;
  lamp_pkg::pattern_t fault_pat;
  lamp_pkg::pattern_t link_pat [2];
  lamp_pkg::port_stat_t port [2];
  logic [1:0] link_lit;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Decode a pattern code into the lamp level.
  function automatic logic show(lamp_pkg::pattern_t p, lamp_pkg::wave_t w);
    case (p)
      lamp_pkg::PAT_OFF: show = 1'b0;
      lamp_pkg::PAT_ON: show = 1'b1;
      lamp_pkg::PAT_FLICKER: show = w.flicker;
      lamp_pkg::PAT_BLINK: show = w.blink;
      lamp_pkg::PAT_SINGLE: show = w.single;
      lamp_pkg::PAT_DOUBLE: show = w.dbl;
      default: show = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Waveforms decoded from the shared counters, so every lamp stays in phase.
  always_comb begin
    wave.flicker = st_ff.flicker;
    wave.blink = st_ff.blink;
    wave.single = (st_ff.single_ms < 11'(lamp_pkg::FLASH_ON_MS));
    wave.dbl = (st_ff.double_ms < 11'(lamp_pkg::FLASH_ON_MS)) ||
               ((st_ff.double_ms >= 11'(lamp_pkg::FLASH_ON_MS + lamp_pkg::FLASH_GAP_MS)) &&
                (st_ff.double_ms < 11'(2 * lamp_pkg::FLASH_ON_MS + lamp_pkg::FLASH_GAP_MS)));
    // The line above forms the lit, dark, lit, long dark frame.
  end

  // Run lamp follows the communication state; without power it is dark.
  always_comb begin
    run_pat = lamp_pkg::PAT_OFF;
    if (power_good) begin
      case (esm_state)
        lamp_pkg::ESM_INIT: run_pat = lamp_pkg::PAT_OFF;
        lamp_pkg::ESM_PREOP: run_pat = lamp_pkg::PAT_BLINK;
        lamp_pkg::ESM_SAFEOP: run_pat = lamp_pkg::PAT_SINGLE;
        lamp_pkg::ESM_OP: run_pat = lamp_pkg::PAT_ON;
        default: run_pat = lamp_pkg::PAT_OFF;
      endcase
    end
  end

  // Fault lamp shows the most severe fault present.
  always_comb begin
    if (comm_err.critical) begin
      fault_pat = lamp_pkg::PAT_ON;
    end else if (comm_err.sm_watchdog) begin
      fault_pat = lamp_pkg::PAT_DOUBLE;
    end else if (comm_err.autonomous) begin
      fault_pat = lamp_pkg::PAT_SINGLE;
    end else if (comm_err.refused) begin
      fault_pat = lamp_pkg::PAT_BLINK;
    end else begin
      fault_pat = lamp_pkg::PAT_OFF;
    end
  end

  // One link lamp per port, each looking only at its own port.
  assign port[0] = in_port_connector;
  assign port[1] = out_port_connector;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!power_good || !port[i].link) begin
        link_pat[i] = lamp_pkg::PAT_OFF;
      end else if (port[i].traffic) begin
        link_pat[i] = lamp_pkg::PAT_FLICKER;
      end else begin
        link_pat[i] = lamp_pkg::PAT_ON;
      end
      link_lit[i] = show(link_pat[i], wave);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: prescaler, pattern counters, bus slave and lamp levels.
  assign addr_ok = (haddr[31:4] == 28'h0000000);
  always_comb begin
    nxt_st = st_ff;
    // Millisecond tick shared by every pattern.
    nxt_st.tick = 1'b0;
    if (st_ff.prescale == 18'(TICK_CYCLES - 1)) begin
      nxt_st.prescale = lamp_pkg::PRESCALE_RST;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.prescale = st_ff.prescale + 18'h00001;
    end
    if (st_ff.tick) begin
      if (st_ff.flick_ms == 6'(lamp_pkg::FLICKER_MS - 1)) begin
        nxt_st.flick_ms = 6'h00;
        nxt_st.flicker = ~st_ff.flicker;
      end else begin
        nxt_st.flick_ms = st_ff.flick_ms + 6'h01;
      end
      if (st_ff.blink_ms == 8'(lamp_pkg::BLINK_MS - 1)) begin
        nxt_st.blink_ms = 8'h00;
        nxt_st.blink = ~st_ff.blink;
      end else begin
        nxt_st.blink_ms = st_ff.blink_ms + 8'h01;
      end
      if (st_ff.single_ms == 11'(lamp_pkg::SINGLE_FRAME_MS - 1)) begin
        nxt_st.single_ms = lamp_pkg::MS_RST;
      end else begin
        nxt_st.single_ms = st_ff.single_ms + 11'h001;
      end
      if (st_ff.double_ms == 11'(lamp_pkg::DOUBLE_FRAME_MS - 1)) begin
        nxt_st.double_ms = lamp_pkg::MS_RST;
      end else begin
        nxt_st.double_ms = st_ff.double_ms + 11'h001;
      end
    end

    // Bus write data arrives one cycle after its address phase.
    if (st_ff.wr_pend && st_ff.wr_addr == CTRL_OFS) begin
      nxt_st.lamp_test = hwdata[0];
      nxt_st.lamp_blank = hwdata[1];
    end
    nxt_st.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      nxt_st.wr_pend = hwrite && addr_ok;
      nxt_st.wr_addr = haddr[3:0];
      nxt_st.rdata = 32'h00000000;
      if (!hwrite && addr_ok) begin
        case (haddr[3:0])
          CTRL_OFS: nxt_st.rdata = {30'h00000000, st_ff.lamp_blank, st_ff.lamp_test};
          STAT_OFS: nxt_st.rdata = {25'h0000000, st_ff.safety, st_ff.line,
                                    st_ff.link, st_ff.fault, st_ff.run};
          default: nxt_st.rdata = 32'h00000000;
        endcase
      end
    end

    // Lamp levels; test overrides blank so the operator can check bulbs.
    nxt_st.run = show(run_pat, wave);
    nxt_st.fault = show(fault_pat, wave);
    nxt_st.link = link_lit;
    nxt_st.line[0] = in_port_connector.rx_error;
    nxt_st.line[1] = out_port_connector.rx_error;
    nxt_st.safety = safety_ready;
    if (st_ff.lamp_test) begin
      nxt_st.run = 1'b1;
      nxt_st.fault = 1'b1;
      nxt_st.link = 2'h3;
      nxt_st.line = 2'h3;
      nxt_st.safety = 1'b1;
    end else if (st_ff.lamp_blank) begin
      nxt_st.run = 1'b0;
      nxt_st.fault = 1'b0;
      nxt_st.link = 2'h0;
      nxt_st.line = 2'h0;
      nxt_st.safety = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs: lamps and read data straight from flip-flops; no wait states.
  assign hrdata = st_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign run_state_lamp = st_ff.run;
  assign comm_fault_lamp = st_ff.fault;
  assign link_act_lamp = st_ff.link;
  assign line_fault_lamp = st_ff.line;
  assign safety_ready_lamp = st_ff.safety;

endmodule // fieldbus_status_led_driver

// ==== sim/lamp_watch.sv ====
/* Operator's view of one panel lamp: times its lit and dark spans.
   Assumes the lamp is sampled on the rising edge of the system clock. */
`timescale 1ns/1ps
module lamp_watch (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic lamp, // Lamp as seen on the panel.
  output int hi_len, // Length of the last lit span.
  output int lo_len, // Length of the last dark span.
  output int lo_prev // Dark span before the last one.
);
  int run_len;
  logic last;
  // Spans are closed at each change, so a partial first span is soon overwritten.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_len <= 1;
      last <= 1'b0;
      hi_len <= 0;
      lo_len <= 0;
      lo_prev <= 0;
    end else if (lamp !== last) begin
      last <= lamp;
      run_len <= 1;
      if (last) begin
        hi_len <= run_len;
      end else begin
        lo_len <= run_len;
        lo_prev <= lo_len;
      end
    end else begin
      run_len <= run_len + 1;
    end
  end
endmodule // lamp_watch

// ==== sim/lamp_chk.sv ====
/* Port assertions for the lamp driver.
   Assumes the lamp test bit is set only while every lamp is lit anyway. */
`timescale 1ns/1ps
module lamp_chk (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic power_good, // Power present.
  input wire lamp_pkg::esm_state_t esm_state, // Slave state.
  input wire lamp_pkg::comm_err_t comm_err, // Fault flags.
  input wire lamp_pkg::port_stat_t in_port_connector, // In port.
  input wire lamp_pkg::port_stat_t out_port_connector, // Out port.
  input wire logic safety_ready, // Safety can be activated.
  input wire logic hreadyout, // Slave ready.
  input wire logic hresp, // Response.
  input wire logic run_state_lamp, // Run lamp.
  input wire logic comm_fault_lamp, // Fault lamp.
  input wire logic [1:0] link_act_lamp, // Link lamps.
  input wire logic [1:0] line_fault_lamp, // Line fault lamps.
  input wire logic safety_ready_lamp // Safety lamp.
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////////
  // Lamp outputs are registered, so each follows its cause by one edge.
  property p_crit; comm_err.critical |=> comm_fault_lamp; endproperty
  a_crit: assert property (p_crit) else $error("fault lamp dark on critical");
  property p_clear; comm_err == 4'h0 |=> !comm_fault_lamp; endproperty
  a_clear: assert property (p_clear) else $error("fault lamp lit, no fault");
  property p_init; power_good && esm_state == lamp_pkg::ESM_INIT |=> !run_state_lamp; endproperty
  a_init: assert property (p_init) else $error("run lamp lit in init");
  property p_nopwr; !power_good |=> !run_state_lamp && link_act_lamp == 2'h0; endproperty
  a_nopwr: assert property (p_nopwr) else $error("lamp lit without power");
  property p_op; power_good && esm_state == lamp_pkg::ESM_OP |=> run_state_lamp; endproperty
  a_op: assert property (p_op) else $error("run lamp dark in op");
  property p_link;
    power_good && in_port_connector.link && !in_port_connector.traffic |=> link_act_lamp[0];
  endproperty
  a_link: assert property (p_link) else $error("link lamp not steady");
  property p_nolink; !out_port_connector.link |=> !link_act_lamp[1]; endproperty
  a_nolink: assert property (p_nolink) else $error("out link lamp lit");
  property p_line;
    1'b1 |=> line_fault_lamp == $past({out_port_connector.rx_error, in_port_connector.rx_error});
  endproperty
  a_line: assert property (p_line) else $error("line lamp wrong");
  property p_safe; 1'b1 |=> safety_ready_lamp == $past(safety_ready); endproperty
  a_safe: assert property (p_safe) else $error("safety lamp wrong");
  // A flicker phase lasts fifty millisecond ticks, so eight lit cycles is a safe floor.
  property p_flick;
    $rose(link_act_lamp[0]) && in_port_connector.traffic |=> link_act_lamp[0] [*8];
  endproperty
  a_flick: assert property (p_flick) else $error("flicker phase too short");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");
  c_run: cover property ($rose(run_state_lamp));
  c_fault: cover property ($rose(comm_fault_lamp));
  c_link: cover property ($rose(link_act_lamp[0]));
endmodule // lamp_chk
bind fieldbus_status_led_driver lamp_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .power_good(power_good), .esm_state(esm_state), .comm_err(comm_err),
  .in_port_connector(in_port_connector), .out_port_connector(out_port_connector),
  .safety_ready(safety_ready), .hreadyout(hreadyout), .hresp(hresp),
  .run_state_lamp(run_state_lamp), .comm_fault_lamp(comm_fault_lamp),
  .link_act_lamp(link_act_lamp), .line_fault_lamp(line_fault_lamp),
  .safety_ready_lamp(safety_ready_lamp));

// ==== sim/test_fieldbus_status_led_driver.sv ====
/* Bench for the lamp driver: lamp mapping, pattern timing, register bus.
   Assumes TICK_CYCLES of 10, so one millisecond is 10 cycles. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module test_fieldbus_status_led_driver;
  localparam int TK = 10; // Cycles per millisecond, small to keep the run short.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic power_good = 1'b0;
  lamp_pkg::esm_state_t esm = lamp_pkg::ESM_INIT;
  lamp_pkg::comm_err_t err = 4'h0;
  lamp_pkg::port_stat_t in_p = 3'h0;
  lamp_pkg::port_stat_t out_p = 3'h0;
  logic safe = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hsel = 1'b0;
  logic hready, hreadyout, hresp, run_l, fault_l, safe_l;
  logic [31:0] hrdata, q;
  logic [1:0] link_l, line_l;
  int fails = 0;
  int n_tests = 0;
  int hi[3], lo[3], lop[3];
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  fieldbus_status_led_driver #(.TICK_CYCLES(TK)) dut (.hclk(hclk), .hresetn(hresetn),
    .power_good(power_good), .esm_state(esm), .comm_err(err), .in_port_connector(in_p),
    .out_port_connector(out_p), .safety_ready(safe), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .run_state_lamp(run_l),
    .comm_fault_lamp(fault_l), .link_act_lamp(link_l), .line_fault_lamp(line_l),
    .safety_ready_lamp(safe_l));
  lamp_watch w0 (.hclk(hclk), .hresetn(hresetn), .lamp(run_l), .hi_len(hi[0]),
    .lo_len(lo[0]), .lo_prev(lop[0]));
  lamp_watch w1 (.hclk(hclk), .hresetn(hresetn), .lamp(fault_l), .hi_len(hi[1]),
    .lo_len(lo[1]), .lo_prev(lop[1]));
  lamp_watch w2 (.hclk(hclk), .hresetn(hresetn), .lamp(link_l[0]), .hi_len(hi[2]),
    .lo_len(lo[2]), .lo_prev(lop[2]));
  //////////////////////////////////////////////////////////////////////////////
  // Checks land at a falling edge, clear of the registers' updates.
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  // One single AHB-Lite transfer; the wait for ready is bounded by the watchdog.
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Every lamp lit at once, with every fault flag raised to test severity.
  task automatic t_steady;
    @(posedge hclk);
    power_good <= 1'b1;
    esm <= lamp_pkg::ESM_OP;
    err <= 4'hf;
    in_p <= 3'b101;
    out_p <= 3'b101;
    safe <= 1'b1;
    wt(300);
    `CHK({run_l, fault_l, link_l, line_l, safe_l}, 7'h7f)
    ahb(1'b1, 32'h0, 32'h1, q);
    ahb(1'b0, 32'h4, 32'h0, q);
    `CHK(q, 32'h0000007f)
    ahb(1'b0, 32'h8, 32'h0, q);
    `CHK(q, 32'h00000000)
    ahb(1'b1, 32'h0, 32'h0, q);
  endtask
  // Power loss, then init with only the out port linked.
  task automatic t_off;
    @(posedge hclk);
    power_good <= 1'b0;
    wt(3);
    `CHK({run_l, link_l, line_l, safe_l}, 6'h07)
    @(posedge hclk);
    power_good <= 1'b1;
    esm <= lamp_pkg::ESM_INIT;
    err <= 4'h0;
    in_p <= 3'b000;
    out_p <= 3'b100;
    safe <= 1'b0;
    wt(3);
    `CHK({run_l, fault_l, link_l, line_l, safe_l}, 7'h10)
    ahb(1'b0, 32'h4, 32'h0, q);
    `CHK(q, 32'h00000008)
    // Blanking darkens the one lamp lit here, and the control word reads back.
    ahb(1'b1, 32'h0, 32'h2, q);
    ahb(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h00000002)
    `CHK(link_l, 2'h0)
    ahb(1'b1, 32'h0, 32'h0, q);
    @(posedge hclk);
    esm <= lamp_pkg::ESM_BOOT;
    wt(3);
    `CHK(run_l, 1'b0)
    `CHK(link_l, 2'h2)
  endtask
  // Blink on run and fault lamps, flicker on the in port link lamp.
  task automatic t_blink;
    @(posedge hclk);
    esm <= lamp_pkg::ESM_PREOP;
    err <= 4'h1;
    in_p <= 3'b110;
    wt(650 * TK);
    `CHK({hi[0], lo[0]}, {200 * TK, 200 * TK})
    `CHK({hi[1], lo[1]}, {200 * TK, 200 * TK})
    `CHK({hi[2], lo[2]}, {50 * TK, 50 * TK})
    `CHK(run_l, fault_l)
  endtask
  // Single flash on the run lamp, double flash wins on the fault lamp.
  task automatic t_flash;
    @(posedge hclk);
    esm <= lamp_pkg::ESM_SAFEOP;
    err <= 4'h7;
    wt(3300 * TK);
    `CHK({hi[0], lo[0]}, {200 * TK, 1000 * TK})
    `CHK(hi[1], 200 * TK)
    `CHK(lo[1] + lop[1], 1200 * TK)
  endtask
  // Single flash wins over blink on the fault lamp; two frames clear the old spans.
  task automatic t_single;
    @(posedge hclk);
    err <= 4'h3;
    wt(2500 * TK);
    `CHK({hi[1], lo[1]}, {200 * TK, 1000 * TK})
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // The whole run is about 65000 cycles; the watchdog allows some 100000.
  initial begin
    #500000;
    fails++;
    print_verdict;
  end
  // Reset for four cycles, then the scenarios in turn.
  initial begin
    wt(3);
    `CHK({hreadyout, run_l, fault_l, link_l, line_l, safe_l}, 8'h80)
    @(posedge hclk);
    hresetn <= 1'b1;
    t_steady;
    t_off;
    t_blink;
    t_flash;
    t_single;
    print_verdict;
  end
endmodule // test_fieldbus_status_led_driver
